// ### src/acs_pkg.sv
`default_nettype none
package acs_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int PRESC_W = 7;
  localparam int DIVSEL_W = 3;
  localparam int CHAN_W = 3;
  localparam int REF_W = 2;
  localparam int HALF_W = 6;
  localparam int CYC_W = 16;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_SELECT = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 4'h4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START = 6;
  localparam int BIT_AUTO = 5;
  localparam int BIT_DONE = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int DIVSEL_LSB = 0;
  localparam int BIT_FREE_RUN = 0;
  localparam int REF_LSB = 6;
  localparam int CHAN_LSB = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DIVSEL_W-1:0] DIVSEL_RST = 3'h0;
  localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
  localparam logic [REF_W-1:0] REF_RST = 2'h0;
  localparam logic [RES_W-1:0] RES_RST = 10'h000;
  localparam logic [RES_W-1:0] FULL_SCALE = 10'h3FF;

  // ****************************************
  // Conversion timing in ADC clock cycles
  // ****************************************
  localparam int NORMAL_CONV_CYC = 15;
  localparam int NORMAL_SAMPLE_CYC = 4;
  localparam int FIRST_CONV_CYC = 26;
  localparam int FIRST_SAMPLE_CYC = 15;
  // Auto figures are 15.5 and 4.5 cycles, kept in half cycles
  localparam int AUTO_CONV_HALVES = 31;
  localparam int AUTO_SAMPLE_HALVES = 9;

  localparam logic [HALF_W-1:0] NORMAL_DONE_H = HALF_W'(2 * NORMAL_CONV_CYC);
  localparam logic [HALF_W-1:0] NORMAL_SAMPLE_H = HALF_W'(2 * NORMAL_SAMPLE_CYC);
  localparam logic [HALF_W-1:0] FIRST_DONE_H = HALF_W'(2 * FIRST_CONV_CYC);
  localparam logic [HALF_W-1:0] FIRST_SAMPLE_H = HALF_W'(2 * FIRST_SAMPLE_CYC);
  localparam logic [HALF_W-1:0] AUTO_DONE_H = HALF_W'(AUTO_CONV_HALVES);
  localparam logic [HALF_W-1:0] AUTO_SAMPLE_H = HALF_W'(AUTO_SAMPLE_HALVES);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_CONV = 2'b10
  } acs_state_t;

  typedef enum logic [1:0] {
    KIND_NORMAL = 2'b00,
    KIND_FIRST = 2'b01,
    KIND_AUTO = 2'b10
  } acs_kind_t;

endpackage : acs_pkg
`default_nettype wire

// ### src/acs_sequencer.sv
// The implementer's own choices: the placing of the registers and the plain strobed port.
`default_nettype none

// Operation
// - Prescaler runs while enabled, reset otherwise
// - ADC clock divided from system clock
// - Start bit begins conversion at next tick
// - Normal and free-running conversions take 15 cycles
// - First conversion after enable takes 26 cycles
// - Sample at 4, or 15 when first
// - Completion stores result, sets flag, clears start
// - Trigger event resets the prescaler
// - Auto: sample 4.5, finish 15.5 cycles
// - Trigger passes two synchroniser flops first
// - Free-running restarts at once, start stays set
// - Channel buffer follows, then locks per conversion
// - Buffer follows again in last cycle
// - Free-run change applies at end of current conversion
// - Quiet sleep with halted core starts conversion
// - Completion request raised even after early wake
// - No automatic power-off in other sleeps
// - Over-range inputs give full-scale code
// - Codes 000/001 divide 2, 010 4, 011 8
// - Clearing enable aborts running conversion
// - Flag cleared by write-one or vector acknowledge
// - Writing zero to start has no effect
module acs_sequencer
  import acs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic trigger_i,
  input wire logic sleep_quiet_i,
  input wire logic cpu_halted_i,
  input wire logic irq_ack_i,
  input wire logic [RES_W-1:0] sar_result_i,
  input wire logic over_range_i,
  output logic analog_enable_o,
  output logic [CHAN_W-1:0] channel_o,
  output logic [REF_W-1:0] reference_o,
  output logic sample_hold_o,
  output logic conv_done_o,
  output logic conv_busy_o,
  output logic irq_o
);

  // ****************************************
  // State
  // ****************************************
  logic enable_q;
  logic auto_q;
  logic irq_en_q;
  logic free_run_q;
  logic done_q;
  logic first_q;
  logic [DIVSEL_W-1:0] divsel_q;
  logic [CHAN_W-1:0] sel_chan_q;
  logic [REF_W-1:0] sel_ref_q;
  logic [CHAN_W-1:0] lock_chan_q;
  logic [REF_W-1:0] lock_ref_q;
  logic [RES_W-1:0] result_q;
  logic [PRESC_W-1:0] presc_q;
  logic [HALF_W-1:0] halfcnt_q;
  logic [HALF_W-1:0] halfcnt_d;
  acs_state_t state_q;
  acs_state_t state_d;
  acs_kind_t kind_q;
  acs_kind_t kind_d;
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_s3_q;
  logic halted_q;
  logic sample_q;
  logic done_pulse_q;
  logic [DATA_W-1:0] rdata_q;

  // ****************************************
  // Register decode
  // ****************************************
  wire wr_ctrl_a = reg_we_i && (reg_addr_i == OFS_CTRL_A);
  wire wr_ctrl_b = reg_we_i && (reg_addr_i == OFS_CTRL_B);
  wire wr_select = reg_we_i && (reg_addr_i == OFS_SELECT);
  wire enable_d = wr_ctrl_a ? reg_wdata_i[BIT_ENABLE] : enable_q;
  // Start written as one requests; zero is ignored
  wire start_req = wr_ctrl_a && reg_wdata_i[BIT_START] && reg_wdata_i[BIT_ENABLE];
  wire flag_clear = (wr_ctrl_a && reg_wdata_i[BIT_DONE]) || irq_ack_i;

  // ****************************************
  // Prescaler and ADC clock ticks
  // ****************************************
  // 000 and 001 divide by 2, then each code doubles
  wire [DIVSEL_W-1:0] div_shift = (divsel_q <= 3'h1) ? 3'h1 : divsel_q;
  wire [PRESC_W:0] div_full = 8'h01 << div_shift;
  wire [PRESC_W-1:0] presc_mask = PRESC_W'(div_full - 8'h01);
  wire [PRESC_W-1:0] presc_mid = presc_mask >> 1;
  wire [PRESC_W-1:0] presc_low = presc_q & presc_mask;
  wire full_tick = (presc_low == presc_mask);
  wire half_tick = full_tick || (presc_low == presc_mid);

  // ****************************************
  // Trigger and sleep start
  // ****************************************
  wire trig_rise = trig_s2_q && !trig_s3_q;
  // Edges during a conversion are dropped
  wire auto_go = enable_q && auto_q && trig_rise && (state_q == ST_IDLE);
  wire quiet_halt = sleep_quiet_i && cpu_halted_i;
  // Only quiet sleep states start; others leave the converter on
  wire sleep_go = quiet_halt && !halted_q && enable_q && !auto_q && irq_en_q
                  && (state_q == ST_IDLE);

  // ****************************************
  // Conversion timing
  // ****************************************
  wire [HALF_W-1:0] done_h = (kind_q == KIND_FIRST) ? FIRST_DONE_H :
                             (kind_q == KIND_AUTO) ? AUTO_DONE_H : NORMAL_DONE_H;
  wire [HALF_W-1:0] sample_h = (kind_q == KIND_FIRST) ? FIRST_SAMPLE_H :
                               (kind_q == KIND_AUTO) ? AUTO_SAMPLE_H : NORMAL_SAMPLE_H;
  wire converting = (state_q == ST_CONV);
  wire conv_end = converting && half_tick && (halfcnt_q == done_h - 6'h01);
  wire sample_now = converting && half_tick && (halfcnt_q == sample_h - 6'h01);
  wire free_mode = auto_q && free_run_q;
  wire conv_start = (state_d == ST_CONV) && (state_q != ST_CONV);
  // Buffer follows when idle and in the final ADC cycle
  wire follow = !converting || (halfcnt_q >= done_h - 6'h02);
  wire [RES_W-1:0] result_in = over_range_i ? FULL_SCALE : sar_result_i;

  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    halfcnt_d = halfcnt_q;
    case (state_q)
      ST_IDLE: begin
        if (auto_go) begin
          state_d = ST_CONV;
          kind_d = first_q ? KIND_FIRST : KIND_AUTO;
          halfcnt_d = '0;
        end else if (start_req || sleep_go) begin
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (full_tick) begin
          state_d = ST_CONV;
          kind_d = first_q ? KIND_FIRST : KIND_NORMAL;
          halfcnt_d = '0;
        end
      end
      ST_CONV: begin
        if (conv_end) begin
          if (free_mode) begin
            kind_d = KIND_NORMAL;
            halfcnt_d = '0;
          end else begin
            state_d = ST_IDLE;
          end
        end else if (half_tick) begin
          halfcnt_d = halfcnt_q + 6'h01;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!enable_d) begin
      state_d = ST_IDLE;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_q <= 1'b0;
      auto_q <= 1'b0;
      irq_en_q <= 1'b0;
      divsel_q <= DIVSEL_RST;
      free_run_q <= 1'b0;
      sel_chan_q <= CHAN_RST;
      sel_ref_q <= REF_RST;
    end else begin
      if (wr_ctrl_a) begin
        enable_q <= reg_wdata_i[BIT_ENABLE];
        auto_q <= reg_wdata_i[BIT_AUTO];
        irq_en_q <= reg_wdata_i[BIT_IRQ_EN];
        divsel_q <= reg_wdata_i[DIVSEL_LSB +: DIVSEL_W];
      end
      if (wr_ctrl_b) begin
        free_run_q <= reg_wdata_i[BIT_FREE_RUN];
      end
      if (wr_select) begin
        sel_chan_q <= reg_wdata_i[CHAN_LSB +: CHAN_W];
        sel_ref_q <= reg_wdata_i[REF_LSB +: REF_W];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      presc_q <= '0;
    end else if (!enable_q || auto_go) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 7'h01;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      kind_q <= KIND_NORMAL;
      halfcnt_q <= '0;
      first_q <= 1'b1;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      halfcnt_q <= halfcnt_d;
      if (!enable_q) begin
        first_q <= 1'b1;
      end else if (conv_start) begin
        first_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_chan_q <= CHAN_RST;
      lock_ref_q <= REF_RST;
    end else if (follow) begin
      lock_chan_q <= sel_chan_q;
      lock_ref_q <= sel_ref_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_q <= RES_RST;
      done_q <= 1'b0;
      sample_q <= 1'b0;
      done_pulse_q <= 1'b0;
    end else begin
      if (conv_end) begin
        result_q <= result_in;
      end
      // Completion wins over a clear in the same cycle
      done_q <= conv_end || (done_q && !flag_clear);
      sample_q <= sample_now;
      done_pulse_q <= conv_end;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
      halted_q <= 1'b0;
    end else begin
      trig_s1_q <= trigger_i;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      halted_q <= quiet_halt;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire [DATA_W-1:0] ctrl_a_rd = {enable_q, state_q != ST_IDLE, auto_q, done_q,
                                 irq_en_q, divsel_q};
  wire [DATA_W-1:0] ctrl_b_rd = {7'h00, free_run_q};
  wire [DATA_W-1:0] select_rd = {sel_ref_q, 3'h0, sel_chan_q};
  wire [DATA_W-1:0] res_lo_rd = result_q[DATA_W-1:0];
  wire [DATA_W-1:0] res_hi_rd = {6'h00, result_q[RES_W-1:DATA_W]};
  wire [DATA_W-1:0] read_mux = (reg_addr_i == OFS_CTRL_A) ? ctrl_a_rd :
                               (reg_addr_i == OFS_CTRL_B) ? ctrl_b_rd :
                               (reg_addr_i == OFS_SELECT) ? select_rd :
                               (reg_addr_i == OFS_RES_LO) ? res_lo_rd :
                               (reg_addr_i == OFS_RES_HI) ? res_hi_rd : 8'h00;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_re_i ? read_mux : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign analog_enable_o = enable_q;
  assign channel_o = lock_chan_q;
  assign reference_o = lock_ref_q;
  assign sample_hold_o = sample_q;
  assign conv_done_o = done_pulse_q;
  assign conv_busy_o = converting;
  // Request stands until cleared, whatever woke the core
  assign irq_o = done_q && irq_en_q;

  // ****************************************
  // Checks
  // ****************************************
  logic [CYC_W-1:0] cyc_q;
  wire [CYC_W-1:0] div_w = CYC_W'(div_full);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_q <= '0;
    end else if (conv_start || (conv_end && free_mode)) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  AST_PRESC_HELD: assert property (!enable_q |=> presc_q == 7'h00)
    else $error("prescaler not held while disabled");
  AST_ARM_START: assert property (state_q == ST_ARMED && full_tick && enable_d
                                  |=> converting && halfcnt_q == 6'h00)
    else $error("conversion did not start on ADC tick");
  AST_NORMAL_LEN: assert property (conv_end && kind_q == KIND_NORMAL
                                   |-> cyc_q == 16'(NORMAL_CONV_CYC) * div_w - 16'h0001)
    else $error("normal conversion length wrong");
  AST_FIRST_LEN: assert property (conv_end && kind_q == KIND_FIRST
                                  |-> cyc_q == 16'(FIRST_CONV_CYC) * div_w - 16'h0001)
    else $error("first conversion length wrong");
  AST_SAMPLE_POS: assert property (sample_now && kind_q == KIND_NORMAL
                                   |-> cyc_q == 16'(NORMAL_SAMPLE_CYC) * div_w - 16'h0001)
    else $error("sample point misplaced");
  AST_COMPLETE: assert property (conv_end |=> done_q && sample_hold_o == 1'b0
                                 && result_q == $past(result_in) && conv_done_o)
    else $error("completion effects missing");
  AST_SINGLE_CLR: assert property (conv_end && !free_mode |=> state_q == ST_IDLE
                                   && !ctrl_a_rd[BIT_START])
    else $error("start bit not cleared at completion");
  AST_TRIG_RESET: assert property (auto_go |=> presc_q == 7'h00 && converting)
    else $error("trigger did not reset prescaler");
  AST_TRIG_SYNC: assert property ($rose(trig_s2_q) |-> $past(trigger_i, 2))
    else $error("trigger synchroniser depth wrong");
  AST_FREE_RUN: assert property (conv_end && free_mode && enable_d
                                 |=> converting && halfcnt_q == 6'h00 && ctrl_a_rd[BIT_START])
    else $error("free running did not restart");
  AST_LOCKED: assert property (converting && !follow |=> $stable(channel_o)
                               && $stable(reference_o))
    else $error("selection changed while locked");
  AST_ABORT: assert property (!enable_d |=> !converting)
    else $error("disable did not abort");
  AST_FLAG_CLR: assert property (done_q && flag_clear && !conv_end |=> !done_q)
    else $error("flag clear failed");

  COV_FIRST: cover property (conv_end && kind_q == KIND_FIRST);
  COV_NORMAL: cover property (conv_end && kind_q == KIND_NORMAL && !free_mode);
  COV_AUTO: cover property (conv_end && kind_q == KIND_AUTO);
  COV_FREE: cover property (conv_end && free_mode ##1 converting);
  COV_SLEEP: cover property (sleep_go ##1 state_q == ST_ARMED);

endmodule : acs_sequencer
`default_nettype wire

// ### test/acs_far_model.sv
`default_nettype none
module acs_far_model
  import acs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic sample_hold_i,
  input wire logic irq_i,
  input wire logic [RES_W-1:0] level_i,
  input wire logic over_i,
  input wire logic trig_req_i,
  input wire logic sleep_req_i,
  input wire logic ack_en_i,
  output logic [RES_W-1:0] sar_result_o,
  output logic over_range_o,
  output logic trigger_o,
  output logic sleep_quiet_o,
  output logic cpu_halted_o,
  output logic irq_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Analog hold, trigger source and core
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sar_result_o <= 10'h2AA;
      over_range_o <= 1'b0;
      trigger_o <= 1'b0;
      sleep_quiet_o <= 1'b0;
      cpu_halted_o <= 1'b0;
      irq_ack_o <= 1'b0;
    end else begin
      // Hold capacitor keeps the sampled level
      if (sample_hold_i) begin
        sar_result_o <= level_i;
        over_range_o <= over_i;
      end
      trigger_o <= trig_req_i;
      sleep_quiet_o <= sleep_req_i;
      // Core halts one cycle after entering sleep
      cpu_halted_o <= sleep_quiet_o & sleep_req_i;
      // Vector taken once per request
      irq_ack_o <= irq_i & ack_en_i & ~irq_ack_o;
    end
  end
endmodule : acs_far_model
`default_nettype wire

// ### test/adc_conversion_sequencer_tb_top.sv
`default_nettype none
module adc_conversion_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import acs_pkg::*;

  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [RES_W-1:0] level = 10'h000;
  logic over = 1'b0;
  logic trig_req = 1'b0;
  logic sleep_req = 1'b0;
  logic ack_en = 1'b0;
  logic [DATA_W-1:0] rdata, rv;
  logic [DATA_W-1:0] ctl = 8'h00;
  logic trig, quiet, halted, ack, ovr, aen, sh, done, busy, irq;
  logic [RES_W-1:0] sar;
  logic [CHAN_W-1:0] chan;
  logic [REF_W-1:0] refsel;
  logic [RES_W-1:0] exp_q[$];
  int n_fail = 0;
  int n_tests = 0;
  int seed = 95;
  int n;

  always #20 clk_sys_i = ~clk_sys_i;

  acs_sequencer dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .trigger_i(trig),
    .sleep_quiet_i(quiet), .cpu_halted_i(halted), .irq_ack_i(ack), .sar_result_i(sar),
    .over_range_i(ovr), .analog_enable_o(aen), .channel_o(chan), .reference_o(refsel),
    .sample_hold_o(sh), .conv_done_o(done), .conv_busy_o(busy), .irq_o(irq)
  );

  acs_far_model far (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sample_hold_i(sh), .irq_i(irq),
    .level_i(level), .over_i(over), .trig_req_i(trig_req), .sleep_req_i(sleep_req),
    .ack_en_i(ack_en), .sar_result_o(sar), .over_range_o(ovr), .trigger_o(trig),
    .sleep_quiet_o(quiet), .cpu_halted_o(halted), .irq_ack_o(ack)
  );

  // ****************************************
  // Reference model and helpers
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (sh === 1'b1) begin
      exp_q.push_back(over ? 10'h3FF : level);
    end
  end

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    n_tests++;
    if (seen !== expv) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : chk

  function automatic bit hit(input int sel);
    case (sel)
      0: return busy === 1'b1;
      1: return done === 1'b1;
      default: return sh === 1'b1;
    endcase
  endfunction : hit

  task automatic wait_for(input int sel, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      cnt++;
    end while (!hit(sel) && cnt < lim);
    if (!hit(sel)) begin
      n_fail++;
      $display("mismatch at %0t: wait for event %0d timed out", $time, sel);
      complete_run();
    end
  endtask : wait_for

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_sys_i);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_sys_i);
    re <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd

  // Kind 0 normal, 1 first, 2 auto; figures in half ADC cycles
  task automatic conv(input int d, input int kind, input bit start);
    int t;
    int s;
    logic [RES_W-1:0] e;
    if (start) wr(OFS_CTRL_A, ctl | 8'h40);
    wait_for(0, 2 * d + 8, t);
    chk(16'(t <= d + 3 || !start), 16'h0001);
    wait_for(2, 30 * d, s);
    wait_for(1, 30 * d, t);
    chk(16'(2 * s), 16'(d * (kind == 1 ? 30 : (kind == 2 ? 9 : 8))));
    chk(16'(2 * (s + t)), 16'(d * (kind == 1 ? 52 : (kind == 2 ? 31 : 30))));
    chk(16'(exp_q.size()), 16'h0001);
    e = exp_q.pop_front();
    rd(OFS_RES_LO);
    chk(rv, e[7:0]);
    rd(OFS_RES_HI);
    chk(rv, {6'h00, e[9:8]});
    rd(OFS_CTRL_A);
    chk(rv, ctl | 8'h10);
    chk(irq, ctl[BIT_IRQ_EN]);
  endtask : conv

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk({aen, busy, irq, chan, refsel}, 16'h0000);
    wr(4'hF, 8'hFF);
    for (int a = 0; a < 6; a++) begin
      rd(a == 5 ? 4'hF : 4'(a));
      chk(rv, 8'h00);
    end
    // Selection written here and once during the first conversion, never under auto or free running
    wr(OFS_SELECT, 8'h85);
    ctl = 8'h89;
    level <= 10'($random(seed));
    fork
      conv(2, 1, 1);
      begin
        wait_for(0, 20, n);
        wr(OFS_SELECT, 8'h03);
        @(posedge clk_sys_i);
        #1;
        chk({chan, refsel}, {3'h5, 2'h2});
        wr(OFS_CTRL_A, ctl);
      end
    join
    chk({chan, refsel}, {3'h3, 2'h0});
    ack_en <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    ack_en <= 1'b0;
    #1;
    chk(irq, 1'b0);
    rd(OFS_CTRL_A);
    chk(rv, ctl);
    // First result after the reference switch would be dropped by software
    for (int c = 0; c < 8; c++) begin
      ctl = 8'h80 | 8'(c);
      wr(OFS_CTRL_A, ctl);
      level <= 10'($random(seed));
      over <= 1'($random(seed));
      conv(c < 2 ? 2 : 1 << c, 0, 1);
      wr(OFS_CTRL_A, ctl | 8'h10);
      rd(OFS_CTRL_A);
      chk(rv, ctl);
    end
    ctl = 8'h81;
    wr(OFS_CTRL_A, ctl | 8'h40);
    wait_for(0, 20, n);
    wr(OFS_CTRL_A, 8'h01);
    @(posedge clk_sys_i);
    #1;
    chk({aen, busy}, 2'b00);
    chk(16'(exp_q.size()), 16'h0000);
    conv(2, 1, 1);
    ctl = 8'hA1;
    wr(OFS_CTRL_A, ctl | 8'h10);
    trig_req <= 1'b1;
    fork
      conv(2, 2, 0);
      begin
        wait_for(0, 20, n);
        trig_req <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        trig_req <= 1'b1;
      end
    join
    repeat (40) @(posedge clk_sys_i);
    #1;
    chk({busy, 15'(exp_q.size())}, 16'h0000);
    trig_req <= 1'b0;
    wr(OFS_CTRL_B, 8'h01);
    wr(OFS_CTRL_A, ctl | 8'h50);
    wait_for(1, 100, n);
    repeat (3) begin
      rd(OFS_CTRL_A);
      chk(rv[BIT_START], 1'b1);
      rd(OFS_RES_LO);
      chk(rv, 8'(exp_q.pop_front()));
      wait_for(1, 100, n);
      chk(16'(n + 4), 16'h001E);
    end
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_A, 8'h01);
    exp_q.delete();
    ctl = 8'h89;
    wr(OFS_CTRL_A, ctl | 8'h10);
    level <= 10'($random(seed));
    over <= 1'b0;
    sleep_req <= 1'b1;
    fork
      conv(2, 1, 0);
      begin
        wait_for(0, 20, n);
        sleep_req <= 1'b0;
      end
    join
    complete_run();
  end
endmodule : adc_conversion_sequencer_tb_top
`default_nettype wire
